/* hdl/chss_slave.v */
// Two-wire slave port of the charger: word reads and writes of settings
// Assumes external pull-ups; bus pins arrive asynchronously to clk_sys_i
`timescale 1ns/1ps
`include "chss_map.vh"
module chss_slave (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire supply_ok_i,
  input wire i2c_mode_i,
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe_o,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_o,
  output reg [15:0] battery_voltage_target_o,
  output reg [15:0] battery_current_target_o,
  output reg [15:0] charger_option_word_o,
  output reg charge_enable_o,
  output reg bus_busy_o
);
  // ----------------------------------------
  // States, one-hot
  // ----------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_RX = 6'h02;
  localparam [5:0] ST_ACK = 6'h04;
  localparam [5:0] ST_TX = 6'h08;
  localparam [5:0] ST_MACK = 6'h10;
  localparam [5:0] ST_WAIT = 6'h20;
  // Byte roles within a transaction
  localparam [1:0] PH_ADDR = 2'h0;
  localparam [1:0] PH_CMD = 2'h1;
  localparam [1:0] PH_LO = 2'h2;
  localparam [1:0] PH_HI = 2'h3;
  localparam [7:0] STRETCH_CYC = `CHSS_STRETCH_CYC;

  wire scl_lvl;
  wire scl_rise;
  wire scl_fall;
  wire sda_lvl;
  wire sda_rise;
  wire sda_fall;
  reg [5:0] st_q;
  reg [1:0] ph_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg [7:0] cmd_q;
  reg [7:0] lo_q;
  reg [15:0] txw_q;
  reg tx_hi_q;
  reg sda_low_q;
  reg stretch_q;
  reg [7:0] str_cnt_q;
  reg live_q;
  reg ack_ok;
  reg cmd_ok;
  reg [1:0] reg_sel;
  reg [15:0] rd_word;
  reg [7:0] rx_byte;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  chss_pin_sync u_scl (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .pin_i(scl_i),
    .level_o(scl_lvl),
    .rise_o(scl_rise),
    .fall_o(scl_fall)
  );
  chss_pin_sync u_sda (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .pin_i(sda_i),
    .level_o(sda_lvl),
    .rise_o(sda_rise),
    .fall_o(sda_fall)
  );

  // ----------------------------------------
  // Open-drain pins: only low is ever driven
  // ----------------------------------------
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_low_q;
  assign scl_o = 1'b0;
  assign scl_oe_o = stretch_q;

  // ----------------------------------------
  // Command decode for either addressing variant
  // ----------------------------------------
  always @* begin
    cmd_ok = 1'b1;
    reg_sel = 2'h0;
    rd_word = 16'h0000;
    rx_byte = {sh_q[6:0], sda_lvl};
    if (!i2c_mode_i) begin
      case (cmd_q)
        `CHSS_CMD_OPT: begin
          reg_sel = 2'h1;
          rd_word = charger_option_word_o;
        end
        `CHSS_CMD_CUR: begin
          reg_sel = 2'h2;
          rd_word = battery_current_target_o;
        end
        `CHSS_CMD_VOLT: begin
          reg_sel = 2'h3;
          rd_word = battery_voltage_target_o;
        end
        `CHSS_CMD_MAKER: rd_word = `CHSS_MAKER_ID;
        `CHSS_CMD_PART: rd_word = `CHSS_PART_ID;
        default: cmd_ok = 1'b0;
      endcase
    end else begin
      case (cmd_q)
        `CHSS_I2C_OPT_LO, `CHSS_I2C_OPT_HI: begin
          reg_sel = 2'h1;
          rd_word = charger_option_word_o;
        end
        `CHSS_I2C_CUR_LO, `CHSS_I2C_CUR_HI: begin
          reg_sel = 2'h2;
          rd_word = battery_current_target_o;
        end
        `CHSS_I2C_VOLT_LO, `CHSS_I2C_VOLT_HI: begin
          reg_sel = 2'h3;
          rd_word = battery_voltage_target_o;
        end
        `CHSS_I2C_PART: rd_word = `CHSS_PART_ID;
        default: cmd_ok = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Address match or command acceptance for the byte just received
  // ----------------------------------------
  // Decided at the falling edge after bit eight, when the shifter holds the whole byte
  always @* begin
    ack_ok = 1'b0;
    if (ph_q == PH_ADDR) begin
      if (i2c_mode_i) begin
        ack_ok = (sh_q[7:1] == `CHSS_ADDR_I2C);
      end else begin
        ack_ok = (sh_q[7:1] == `CHSS_ADDR_SMB);
      end
    end else begin
      ack_ok = 1'b1;
    end
  end

  // ----------------------------------------
  // Supply gate and bus busy flag
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      live_q <= 1'b0;
      bus_busy_o <= 1'b0;
    end else begin
      live_q <= supply_ok_i;
      if (!live_q) begin
        bus_busy_o <= 1'b0;
      end else if (scl_lvl && sda_fall) begin
        bus_busy_o <= 1'b1;
      end else if (scl_lvl && sda_rise) begin
        bus_busy_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Serial state machine; SDA moves only after SCL falls
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= ST_IDLE;
      ph_q <= PH_ADDR;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      cmd_q <= 8'h00;
      lo_q <= 8'h00;
      txw_q <= 16'h0000;
      tx_hi_q <= 1'b0;
      sda_low_q <= 1'b0;
      stretch_q <= 1'b0;
      str_cnt_q <= 8'h00;
      charger_option_word_o <= `CHSS_OPT_RST;
      battery_current_target_o <= `CHSS_CUR_RST;
      battery_voltage_target_o <= `CHSS_VOLT_RST;
    end else if (!live_q) begin
      st_q <= ST_IDLE;
      sda_low_q <= 1'b0;
      stretch_q <= 1'b0;
    end else if (scl_lvl && sda_fall) begin
      // Start or repeated start restarts address reception
      st_q <= ST_RX;
      ph_q <= PH_ADDR;
      bit_q <= 4'h0;
      sda_low_q <= 1'b0;
      stretch_q <= 1'b0;
    end else if (scl_lvl && sda_rise) begin
      st_q <= ST_IDLE;
      sda_low_q <= 1'b0;
      stretch_q <= 1'b0;
    end else begin
      // Short stretch after each ack the slave gives (none after a master ack) lets the register file settle
      if (stretch_q) begin
        if (str_cnt_q == 8'h00) begin
          stretch_q <= 1'b0;
        end else begin
          str_cnt_q <= str_cnt_q - 8'h01;
        end
      end
      case (st_q)
        ST_IDLE: begin
          sda_low_q <= 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            sh_q <= rx_byte;
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            // Ninth clock: acknowledge or refuse
            bit_q <= 4'h0;
            if (!ack_ok || (ph_q != PH_ADDR && ph_q != PH_CMD && !cmd_ok)) begin
              st_q <= ST_IDLE;
            end else begin
              sda_low_q <= 1'b1;
              st_q <= ST_ACK;
              stretch_q <= 1'b1;
              str_cnt_q <= STRETCH_CYC;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            sda_low_q <= 1'b0;
            st_q <= ST_RX;
            case (ph_q)
              PH_ADDR: begin
                if (sh_q[0]) begin
                  // Read direction: first data bit out now
                  txw_q <= rd_word;
                  tx_hi_q <= 1'b0;
                  sda_low_q <= !rd_word[7];
                  bit_q <= 4'h0;
                  st_q <= ST_TX;
                end else begin
                  ph_q <= PH_CMD;
                end
              end
              PH_CMD: begin
                cmd_q <= sh_q;
                ph_q <= PH_LO;
              end
              PH_LO: begin
                lo_q <= sh_q;
                ph_q <= PH_HI;
              end
              default: begin
                // Whole word commits on high byte ack
                case (reg_sel)
                  2'h1: charger_option_word_o <= {sh_q, lo_q};
                  2'h2: battery_current_target_o <= {sh_q, lo_q};
                  2'h3: battery_voltage_target_o <= {sh_q, lo_q};
                  default: lo_q <= lo_q;
                endcase
                ph_q <= PH_LO;
              end
            endcase
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_q == 4'h7) begin
              sda_low_q <= 1'b0;
              st_q <= ST_MACK;
            end else begin
              bit_q <= bit_q + 4'h1;
              if (tx_hi_q) begin
                sda_low_q <= !txw_q[14 - bit_q];
              end else begin
                sda_low_q <= !txw_q[6 - bit_q];
              end
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            if (sda_lvl || tx_hi_q) begin
              st_q <= ST_WAIT;
            end else begin
              st_q <= ST_ACK;
            end
          end
        end
        ST_WAIT: begin
          sda_low_q <= 1'b0;
        end
        default: st_q <= ST_IDLE;
      endcase
      // Master acked low byte: send high byte next
      if (st_q == ST_MACK && scl_rise && !sda_lvl && !tx_hi_q) begin
        st_q <= ST_WAIT;
        tx_hi_q <= 1'b1;
        bit_q <= 4'h0;
      end
      if (st_q == ST_WAIT && tx_hi_q && scl_fall && bit_q == 4'h0 && ph_q != PH_HI) begin
        sda_low_q <= !txw_q[15];
        st_q <= ST_TX;
        ph_q <= PH_HI;
      end
    end
  end

  // ----------------------------------------
  // Charge enable from option inhibit and current target
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      charge_enable_o <= 1'b0;
    end else begin
      charge_enable_o <= !charger_option_word_o[`CHSS_INHIBIT_BIT] &&
        (battery_current_target_o != 16'h0000);
    end
  end
endmodule

/* hdl/chss_map.vh */
// Constants for the charger host serial slave: addresses, commands, reset values
// Assumes inclusion by the slave and its self-checking bench only
`ifndef CHSS_MAP_VH
`define CHSS_MAP_VH
`define CHSS_ADDR_SMB 7'h09
`define CHSS_ADDR_I2C 7'h6A
`define CHSS_CMD_OPT 8'h12
`define CHSS_CMD_CUR 8'h14
`define CHSS_CMD_VOLT 8'h15
`define CHSS_CMD_MAKER 8'hFE
`define CHSS_CMD_PART 8'hFF
`define CHSS_I2C_OPT_LO 8'h00
`define CHSS_I2C_OPT_HI 8'h01
`define CHSS_I2C_CUR_LO 8'h0A
`define CHSS_I2C_CUR_HI 8'h0B
`define CHSS_I2C_VOLT_LO 8'h0C
`define CHSS_I2C_VOLT_HI 8'h0D
`define CHSS_I2C_PART 8'h09
`define CHSS_I2C_TOP 8'h0F
`define CHSS_OPT_RST 16'hE14E
`define CHSS_CUR_RST 16'h0000
`define CHSS_VOLT_RST 16'h0000
`define CHSS_INHIBIT_BIT 0
// Arbitrary identification values
`define CHSS_MAKER_ID 16'h00A5
`define CHSS_PART_ID 16'h005A
// Stretch after each byte the slave acknowledges: 100 cycles, 1 us at 100 MHz
`define CHSS_STRETCH_CYC 8'h64
`endif

/* hdl/chss_pin_sync.v */
// Three-stage synchroniser for one bus pin with edge pulses
// Assumes the pin is asynchronous to clk_sys_i
`timescale 1ns/1ps
module chss_pin_sync (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire pin_i,
  output wire level_o,
  output wire rise_o,
  output wire fall_o
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg lvl_q;
  // ----------------------------------------
  // Level changes once stages two and three agree
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      lvl_q <= 1'b1;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end
  assign level_o = lvl_q;
  assign rise_o = (s2_q == s3_q) && s3_q && !lvl_q;
  assign fall_o = (s2_q == s3_q) && !s3_q && lvl_q;
endmodule

/* test/chss_sva.sv */
// Port assertions for the charger host serial slave
// Assumes bus wires are resolved with pull-ups before reaching the pins
`timescale 1ns/1ps
module chss_sva (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire supply_ok_i,
  input wire i2c_mode_i,
  input wire scl_i,
  input wire scl_o,
  input wire scl_oe_o,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire [15:0] battery_voltage_target_o,
  input wire [15:0] battery_current_target_o,
  input wire [15:0] charger_option_word_o,
  input wire charge_enable_o,
  input wire bus_busy_o
);
  // ----------------------------------------
  // Run-length counters
  // ----------------------------------------
  reg [7:0] hi_cnt_q;
  reg [7:0] st_cnt_q;
  // Saturate the high count, since idle SCL stays high for ages
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_cnt_q <= 8'h00;
      st_cnt_q <= 8'h00;
    end else begin
      hi_cnt_q <= scl_i ? hi_cnt_q + {7'h00, hi_cnt_q != 8'hFF} : 8'h00;
      st_cnt_q <= scl_oe_o ? st_cnt_q + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  a_pins_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("pin driven high");
  a_stretch_only_low: assert property ($rose(scl_oe_o) |-> !$past(scl_i))
    else $error("clock pulled while master held it high");
  a_sda_hold_high: assert property (hi_cnt_q > 8'h04 |-> $stable(sda_oe_o))
    else $error("data changed while clock high");
  a_busy_on_start: assert property ($fell(sda_i) && scl_i && $past(scl_i)
    && supply_ok_i && $past(supply_ok_i) |-> ##[1:8] bus_busy_o)
    else $error("start not seen");
  a_idle_on_stop: assert property ($rose(sda_i) && scl_i && $past(scl_i)
    |-> ##[1:8] !bus_busy_o)
    else $error("stop not seen");
  a_lockout_quiet: assert property (!supply_ok_i && !$past(supply_ok_i)
    && !$past(supply_ok_i, 2)
    |-> !sda_oe_o && !scl_oe_o)
    else $error("bus driven below lockout");
  a_enable_rule: assert property ($stable(charger_option_word_o)
    && $stable(battery_current_target_o) |-> charge_enable_o ==
    (!charger_option_word_o[0] && battery_current_target_o != 16'h0000))
    else $error("charge enable wrong");
  a_commit_in_frame: assert property (!$stable({battery_voltage_target_o,
    battery_current_target_o, charger_option_word_o}) |-> bus_busy_o && !scl_i)
    else $error("word changed outside a byte boundary");
  a_stretch_len: assert property ($fell(scl_oe_o)
    |-> st_cnt_q >= 8'h5A && st_cnt_q <= 8'h6E)
    else $error("stretch length off");
endmodule
bind chss_slave chss_sva u_chss_sva (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
  .supply_ok_i(supply_ok_i), .i2c_mode_i(i2c_mode_i), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .battery_voltage_target_o(battery_voltage_target_o),
  .battery_current_target_o(battery_current_target_o),
  .charger_option_word_o(charger_option_word_o),
  .charge_enable_o(charge_enable_o), .bus_busy_o(bus_busy_o));

/* test/chss_host.sv */
// Bus master model that talks to the charger slave
// Assumes the bench resolves both wires with pull-ups
`timescale 1ns/1ps
module chss_host (
  input wire scl_i,
  input wire sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o
);
  // ----------------------------------------
  // Bit, byte and word tasks
  // ----------------------------------------
  localparam int HALF = 80;
  localparam int QTR = 40;
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
  end
  // Data moves a quarter period after SCL falls, so the slave never sees it move with SCL high
  task automatic bit_x(input logic b, output logic r);
    #QTR sda_oe_o = !b;
    #QTR scl_oe_o = 1'b0;
    wait (scl_i);
    #HALF r = sda_i;
    scl_oe_o = 1'b1;
  endtask
  task automatic start();
    #QTR sda_oe_o = 1'b0;
    #QTR scl_oe_o = 1'b0;
    wait (scl_i);
    #HALF sda_oe_o = 1'b1;
    #HALF scl_oe_o = 1'b1;
  endtask
  task automatic stop();
    #QTR sda_oe_o = 1'b1;
    #QTR scl_oe_o = 1'b0;
    wait (scl_i);
    #HALF sda_oe_o = 1'b0;
    #HALF;
  endtask
  task automatic tx(input logic [7:0] d, output logic k);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, k);
  endtask
  task automatic rx(input logic n, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(n, r);
  endtask
  // Write of nb data bytes, low first; unsent bytes report as refused
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
                    input int nb, output logic [3:0] k);
    k = 4'hF;
    start();
    tx({a, 1'b0}, k[3]);
    tx(c, k[2]);
    if (nb > 0) tx(d[7:0], k[1]);
    if (nb > 1) tx(d[15:8], k[0]);
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [15:0] d,
                    output logic [2:0] k);
    start();
    tx({a, 1'b0}, k[2]);
    tx(c, k[1]);
    start();
    tx({a, 1'b1}, k[0]);
    rx(1'b0, d[7:0]);
    rx(1'b1, d[15:8]);
    stop();
  endtask
endmodule

/* test/chss_slave_test.sv */
// Self-checking bench for the charger host serial slave
// Assumes the host model is the only other party on the two wires
`timescale 1ns/1ps
`include "chss_map.vh"
module chss_slave_test;
  // ----------------------------------------
  // Wires, counters and helpers
  // ----------------------------------------
  logic clk_sys_i;
  logic nrst_i = 1'b0;
  logic supply_ok_i = 1'b1;
  logic i2c_mode_i = 1'b0;
  logic scl_oe, sda_oe, h_scl, h_sda, en, busy;
  logic [15:0] vt, ct, ow, rdat;
  logic [3:0] k;
  logic [2:0] kr;
  int errors = 0;
  int n_compared = 0;
  // Pull-ups: a wire is low only while someone pulls it
  wire scl_w = ~(h_scl | scl_oe);
  wire sda_w = ~(h_sda | sda_oe);
  // Rows: mode, expected enable, command, data
  logic [25:0] rows [6] = '{{2'b00, 8'h15, 16'h1234}, {2'b01, 8'h14, 16'h0F80},
    {2'b00, 8'h12, 16'hE14F}, {2'b10, 8'h0C, 16'h5678}, {2'b11, 8'h00, 16'hE14E},
    {2'b10, 8'h0A, 16'h0000}};
  chss_slave u_chss_slave (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .supply_ok_i(supply_ok_i), .i2c_mode_i(i2c_mode_i), .scl_i(scl_w), .scl_o(),
    .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe),
    .battery_voltage_target_o(vt), .battery_current_target_o(ct),
    .charger_option_word_o(ow), .charge_enable_o(en), .bus_busy_o(busy));
  chss_host u_chss_host (.scl_i(scl_w), .sda_i(sda_w), .scl_oe_o(h_scl), .sda_oe_o(h_sda));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [15:0] sel_reg(input logic [7:0] c);
    return (c == 8'h15 || c == 8'h0C) ? vt : (c == 8'h14 || c == 8'h0A) ? ct : ow;
  endfunction
  task automatic do_reset();
    @(posedge clk_sys_i) nrst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    chk(ow, `CHSS_OPT_RST);
    chk(ct, `CHSS_CUR_RST);
    chk(vt, `CHSS_VOLT_RST);
    chk({14'h0000, busy, en}, 16'h0000);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [6:0] a;
    do_reset();
    // Write each word, then read it back in the same mode
    foreach (rows[i]) begin
      @(posedge clk_sys_i) i2c_mode_i <= rows[i][25];
      @(posedge clk_sys_i);
      a = rows[i][25] ? 7'h6A : 7'h09;
      u_chss_host.wr(a, rows[i][23:16], rows[i][15:0], 2, k);
      chk({12'h000, k}, 16'h0000);
      chk(sel_reg(rows[i][23:16]), rows[i][15:0]);
      chk({15'h0000, en}, {15'h0000, rows[i][24]});
      u_chss_host.rd(a, rows[i][23:16], rdat, kr);
      chk({13'h0000, kr}, 16'h0000);
      chk(rdat, rows[i][15:0]);
    end
    // Part id in the I2C variant, then back to SMBus addressing
    u_chss_host.rd(7'h6A, `CHSS_I2C_PART, rdat, kr);
    chk({13'h0000, kr}, 16'h0000);
    chk(rdat, `CHSS_PART_ID);
    @(posedge clk_sys_i) i2c_mode_i <= 1'b0;
    // Maker id stays put even after a write attempt; part id is read back too
    u_chss_host.wr(7'h09, 8'hFE, 16'h1111, 2, k);
    u_chss_host.rd(7'h09, 8'hFE, rdat, kr);
    chk(rdat, `CHSS_MAKER_ID);
    u_chss_host.rd(7'h09, 8'hFF, rdat, kr);
    chk(rdat, `CHSS_PART_ID);
    // Foreign address, then an undefined command
    u_chss_host.wr(7'h6A, 8'h15, 16'hBEEF, 2, k);
    chk({12'h000, k}, 16'h000F);
    u_chss_host.wr(7'h09, 8'h20, 16'hBEEF, 2, k);
    chk({12'h000, k}, 16'h0003);
    // Stop after the low byte must leave the word untouched
    u_chss_host.wr(7'h09, 8'h15, 16'hBEEF, 1, k);
    chk({12'h000, k}, 16'h0001);
    chk(vt, 16'h5678);
    // Below the lockout level nothing answers
    @(posedge clk_sys_i) supply_ok_i <= 1'b0;
    u_chss_host.wr(7'h09, 8'h15, 16'hBEEF, 2, k);
    chk({12'h000, k}, 16'h000F);
    chk(vt, 16'h5678);
    @(posedge clk_sys_i) supply_ok_i <= 1'b1;
    do_reset();
    summarize();
  end
  // Watchdog well beyond the expected few hundred microseconds
  initial begin
    #900000;
    errors++;
    summarize();
  end
endmodule
